// *** core/chip_select_decoder_consts.vh ***
// Register offsets, field positions, reset values and cycle kinds of the chip-select decoder.
`ifndef CHIP_SELECT_DECODER_CONSTS_VH
`define CHIP_SELECT_DECODER_CONSTS_VH

`define CSD_OFS_LOWER_CTRL   8'h00
`define CSD_OFS_UPPER_CTRL   8'h04
`define CSD_OFS_MID_CTRL     8'h08
`define CSD_OFS_SHARED_CTRL  8'h0c
`define CSD_OFS_PERIPH_CTRL  8'h10
`define CSD_OFS_STATUS       8'h14

`define CSD_CTRL_RESET       16'h0000

`define CSD_WAIT_LSB         0
`define CSD_WAIT_MSB         1
`define CSD_RDY_IGN_BIT      2
`define CSD_SIZE_LSB         4
`define CSD_SIZE_MSB         7
`define CSD_MSIZE_LSB        4
`define CSD_MSIZE_MSB        6
`define CSD_SPACE_BIT        7
`define CSD_MBASE_LSB        9
`define CSD_MBASE_MSB        15
`define CSD_PBASE_LSB        6
`define CSD_PBASE_MSB        15

`define CSD_SIZE_CODE_MAX    4'h8
`define CSD_MSIZE_CODE_MAX   3'h6
`define CSD_PERIPH_LINES     7
`define CSD_PERIPH_SPAN      10'h380
`define CSD_TOP_BLOCKS       10'h3ff

`define CSD_KIND_IDLE        3'h0
`define CSD_KIND_MEM_RD      3'h1
`define CSD_KIND_MEM_WR      3'h2
`define CSD_KIND_PREFETCH    3'h3
`define CSD_KIND_IO_RD       3'h4
`define CSD_KIND_IO_WR       3'h5

`endif

// *** core/chip_select_decoder.v ***
// Address-window chip-select decoder with wait-state and ready control behind an APB slave.
//
// How it works
// - Peripheral line n selects base+n*128 through base+n*128+127, seven lines.
// - Upper memory window always ends at address 0FFFFFH.
// - Lower memory window covers zero through block size minus one.
// - Lower and upper block sizes are 1 to 256 Kbytes in powers of two.
// - Mid-range block splits into four consecutive quarters, one per select line.
// - A 512-Kbyte mid-range block with base bit 19 set overlaps the upper window.
// - Each window inserts zero to three wait states from its wait count field.
// - Ready-ignore bit chooses ready-terminated or unconditional end after waits.
// - Programmed wait states always elapse before external ready is honoured.
// - Ignoring ready, the cycle ends after the waits; ready cannot extend it.
// - Every enabled window holding the address asserts, overlaps included.
// - Any active mid-range line makes the shared control timing govern the cycle.
// - Peripheral overlapping lower or upper takes that window's timing.
// - Space-select bit places peripheral lines in memory or I/O cycles.
// - Upper and mid-range lines assert only on memory-space cycles.
// - CPU, DMA and refresh cycles are decoded alike.
// - Any read or write of its own register enables lower or upper; mid-range and peripheral also need the shared register accessed.
// - An enabled window stays enabled until reset; writes only retune it.
// - Only internal cycles decode; all selects idle while the bus is granted away.
// - Lower memory window always begins at address zero.
// - Upper window begins at 1 Mbyte minus its block size.
// - Peripheral base sits on any 1-Kbyte boundary in memory or I/O space.
`timescale 1ns/1ps
`include "chip_select_decoder_consts.vh"

module chip_select_decoder (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        CYCLE_START,
    input  wire [19:0] CYCLE_ADDR,
    input  wire [2:0]  CYCLE_KIND,
    input  wire        BUS_GRANT_ACKNOWLEDGE,
    input  wire        BUS_READY,
    output reg         CYCLE_DONE,
    output reg         UPPER_MEMORY_SELECT_N,
    output reg         LOWER_MEMORY_SELECT_N,
    output reg  [3:0]  MIDRANGE_MEMORY_SELECT_N,
    output reg  [6:0]  PERIPHERAL_SELECT_N
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_WAIT  = 2'h1;
    localparam [1:0] ST_READY = 2'h2;

    reg  [15:0] lower_window_control_q;
    reg  [15:0] upper_window_control_q;
    reg  [15:0] midrange_window_control_q;
    reg  [15:0] shared_midrange_peripheral_control_q;
    reg  [15:0] peripheral_window_control_q;
    reg         lower_en_q;
    reg         upper_en_q;
    reg         mid_touched_q;
    reg         shared_touched_q;
    reg         periph_touched_q;
    reg  [1:0]  state_q;
    reg  [1:0]  wait_cnt_q;
    reg         ignore_ready_q;
    reg         ready_s1_q;
    reg         ready_s2_q;
    reg         ready_s3_q;
    reg         ready_q;

    wire        mid_en    = mid_touched_q & shared_touched_q;
    wire        periph_en = periph_touched_q & shared_touched_q;

    // APB access phase that completes at this edge.
    wire        apb_done  = PSEL & PENABLE & PREADY;
    wire        apb_first = PSEL & PENABLE & ~PREADY;

    wire        is_lower  = (PADDR == `CSD_OFS_LOWER_CTRL);
    wire        is_upper  = (PADDR == `CSD_OFS_UPPER_CTRL);
    wire        is_mid    = (PADDR == `CSD_OFS_MID_CTRL);
    wire        is_shared = (PADDR == `CSD_OFS_SHARED_CTRL);
    wire        is_periph = (PADDR == `CSD_OFS_PERIPH_CTRL);
    wire        is_status = (PADDR == `CSD_OFS_STATUS);
    wire        mapped    = is_lower | is_upper | is_mid | is_shared | is_periph | is_status;

    // Window decode, all combinational on the cycle address.
    reg  [3:0]  low_code;
    reg  [3:0]  up_code;
    reg  [2:0]  mid_code;
    reg  [9:0]  kb_mask;
    reg  [9:0]  up_mask;
    reg  [20:0] mid_size;
    reg  [19:0] mid_base;
    reg  [19:0] mid_off;
    reg  [1:0]  mid_idx;
    reg  [19:0] per_base;
    reg  [19:0] per_off;
    reg         mem_cycle;
    reg         io_cycle;
    reg         hit_lower;
    reg         hit_upper;
    reg  [3:0]  hit_mid;
    reg  [6:0]  hit_per;
    reg  [2:0]  timing;
    integer     i;

    always @* begin
        low_code  = lower_window_control_q[`CSD_SIZE_MSB:`CSD_SIZE_LSB];
        up_code   = upper_window_control_q[`CSD_SIZE_MSB:`CSD_SIZE_LSB];
        mid_code  = shared_midrange_peripheral_control_q[`CSD_MSIZE_MSB:`CSD_MSIZE_LSB];
        if (low_code > `CSD_SIZE_CODE_MAX) begin
            low_code = `CSD_SIZE_CODE_MAX;
        end
        if (up_code > `CSD_SIZE_CODE_MAX) begin
            up_code = `CSD_SIZE_CODE_MAX;
        end
        if (mid_code > `CSD_MSIZE_CODE_MAX) begin
            mid_code = `CSD_MSIZE_CODE_MAX;
        end
        // Refresh and DMA cycles arrive on the same kind code as the CPU's.
        mem_cycle = (CYCLE_KIND == `CSD_KIND_MEM_RD) | (CYCLE_KIND == `CSD_KIND_MEM_WR) |
                    (CYCLE_KIND == `CSD_KIND_PREFETCH);
        io_cycle  = (CYCLE_KIND == `CSD_KIND_IO_RD) | (CYCLE_KIND == `CSD_KIND_IO_WR);

        kb_mask   = (10'h001 << low_code) - 10'h001;
        hit_lower = lower_en_q & mem_cycle & ((CYCLE_ADDR[19:10] & ~kb_mask) == 10'h000);
        up_mask   = (10'h001 << up_code) - 10'h001;
        hit_upper = upper_en_q & mem_cycle &
                    ((CYCLE_ADDR[19:10] | up_mask) == `CSD_TOP_BLOCKS);

        // A 512-Kbyte block with base bit 19 set simply lands in the upper half and overlaps.
        mid_size  = 21'h002000 << mid_code;
        mid_base  = {midrange_window_control_q[`CSD_MBASE_MSB:`CSD_MBASE_LSB], 13'h0000};
        mid_off   = CYCLE_ADDR - mid_base;
        mid_idx   = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if ((mid_off >> (11 + mid_code)) == i) begin
                mid_idx = i[1:0];
            end
        end
        hit_mid   = 4'h0;
        if (mid_en && mem_cycle && (CYCLE_ADDR >= mid_base) && ({1'b0, mid_off} < mid_size)) begin
            hit_mid[mid_idx] = 1'b1;
        end

        per_base  = {peripheral_window_control_q[`CSD_PBASE_MSB:`CSD_PBASE_LSB], 10'h000};
        per_off   = CYCLE_ADDR - per_base;
        hit_per   = 7'h00;
        if (periph_en && (CYCLE_ADDR >= per_base) && (per_off < {10'h000, `CSD_PERIPH_SPAN}) &&
            (shared_midrange_peripheral_control_q[`CSD_SPACE_BIT] ? mem_cycle : io_cycle)) begin
            hit_per[per_off[9:7]] = 1'b1;
        end

        // Timing source: mid-range first, then lower/upper under a peripheral overlap.
        if (hit_mid != 4'h0) begin
            timing = shared_midrange_peripheral_control_q[2:0];
        end else if (hit_lower) begin
            timing = lower_window_control_q[2:0];
        end else if (hit_upper) begin
            timing = upper_window_control_q[2:0];
        end else if (hit_per[6:4] != 3'h0) begin
            timing = shared_midrange_peripheral_control_q[2:0];
        end else if (hit_per[3:0] != 4'h0) begin
            timing = peripheral_window_control_q[2:0];
        end else begin
            timing = 3'h0;
        end
    end

    // Control registers and sticky enables.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            lower_window_control_q               <= `CSD_CTRL_RESET;
            upper_window_control_q               <= `CSD_CTRL_RESET;
            midrange_window_control_q            <= `CSD_CTRL_RESET;
            shared_midrange_peripheral_control_q <= `CSD_CTRL_RESET;
            peripheral_window_control_q          <= `CSD_CTRL_RESET;
            lower_en_q                           <= 1'b0;
            upper_en_q                           <= 1'b0;
            mid_touched_q                        <= 1'b0;
            shared_touched_q                     <= 1'b0;
            periph_touched_q                     <= 1'b0;
        end else if (apb_done) begin
            if (PWRITE && is_lower) begin
                lower_window_control_q <= PWDATA[15:0];
            end
            if (PWRITE && is_upper) begin
                upper_window_control_q <= PWDATA[15:0];
            end
            if (PWRITE && is_mid) begin
                midrange_window_control_q <= PWDATA[15:0];
            end
            if (PWRITE && is_shared) begin
                shared_midrange_peripheral_control_q <= PWDATA[15:0];
            end
            if (PWRITE && is_periph) begin
                peripheral_window_control_q <= PWDATA[15:0];
            end
            // Enables only ever set; a read counts as much as a write.
            lower_en_q       <= lower_en_q | is_lower;
            upper_en_q       <= upper_en_q | is_upper;
            mid_touched_q    <= mid_touched_q | is_mid;
            shared_touched_q <= shared_touched_q | is_shared;
            periph_touched_q <= periph_touched_q | is_periph;
        end
    end

    // APB answer: one wait cycle, data and error registered together with ready.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= apb_first;
            PSLVERR <= apb_first & ~mapped;
            if (apb_first && !PWRITE) begin
                case (1'b1)
                    is_lower:  PRDATA <= {16'h0000, lower_window_control_q};
                    is_upper:  PRDATA <= {16'h0000, upper_window_control_q};
                    is_mid:    PRDATA <= {16'h0000, midrange_window_control_q};
                    is_shared: PRDATA <= {16'h0000, shared_midrange_peripheral_control_q};
                    is_periph: PRDATA <= {16'h0000, peripheral_window_control_q};
                    is_status: PRDATA <= {12'h000, ~PERIPHERAL_SELECT_N, ~MIDRANGE_MEMORY_SELECT_N,
                                          ~UPPER_MEMORY_SELECT_N, ~LOWER_MEMORY_SELECT_N,
                                          ready_q, state_q, periph_en, mid_en, upper_en_q, lower_en_q};
                    default:   PRDATA <= 32'h00000000;
                endcase
            end else begin
                PRDATA <= 32'h00000000;
            end
        end
    end

    // External ready pin; a change is accepted once the last two stages agree.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ready_s1_q <= 1'b0;
            ready_s2_q <= 1'b0;
            ready_s3_q <= 1'b0;
            ready_q    <= 1'b0;
        end else begin
            ready_s1_q <= BUS_READY;
            ready_s2_q <= ready_s1_q;
            ready_s3_q <= ready_s2_q;
            if (ready_s2_q == ready_s3_q) begin
                ready_q <= ready_s3_q;
            end
        end
    end

    // Bus cycle sequencer. Selects are registered so they never glitch on address settling.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q                  <= ST_IDLE;
            wait_cnt_q               <= 2'h0;
            ignore_ready_q           <= 1'b0;
            CYCLE_DONE               <= 1'b0;
            UPPER_MEMORY_SELECT_N    <= 1'b1;
            LOWER_MEMORY_SELECT_N    <= 1'b1;
            MIDRANGE_MEMORY_SELECT_N <= 4'hf;
            PERIPHERAL_SELECT_N      <= 7'h7f;
        end else begin
            CYCLE_DONE <= 1'b0;
            if (BUS_GRANT_ACKNOWLEDGE) begin
                // An external master owns the bus; nothing it drives is decoded.
                state_q                  <= ST_IDLE;
                UPPER_MEMORY_SELECT_N    <= 1'b1;
                LOWER_MEMORY_SELECT_N    <= 1'b1;
                MIDRANGE_MEMORY_SELECT_N <= 4'hf;
                PERIPHERAL_SELECT_N      <= 7'h7f;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (CYCLE_START) begin
                            UPPER_MEMORY_SELECT_N    <= ~hit_upper;
                            LOWER_MEMORY_SELECT_N    <= ~hit_lower;
                            MIDRANGE_MEMORY_SELECT_N <= ~hit_mid;
                            PERIPHERAL_SELECT_N      <= ~hit_per;
                            wait_cnt_q               <= timing[`CSD_WAIT_MSB:`CSD_WAIT_LSB];
                            ignore_ready_q           <= timing[`CSD_RDY_IGN_BIT];
                            state_q                  <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (wait_cnt_q != 2'h0) begin
                            wait_cnt_q <= wait_cnt_q - 2'h1;
                        end else if (ignore_ready_q) begin
                            CYCLE_DONE               <= 1'b1;
                            state_q                  <= ST_IDLE;
                            UPPER_MEMORY_SELECT_N    <= 1'b1;
                            LOWER_MEMORY_SELECT_N    <= 1'b1;
                            MIDRANGE_MEMORY_SELECT_N <= 4'hf;
                            PERIPHERAL_SELECT_N      <= 7'h7f;
                        end else begin
                            state_q <= ST_READY;
                        end
                    end
                    ST_READY: begin
                        // Ready is only looked at once every programmed wait has elapsed.
                        if (ready_q) begin
                            CYCLE_DONE               <= 1'b1;
                            state_q                  <= ST_IDLE;
                            UPPER_MEMORY_SELECT_N    <= 1'b1;
                            LOWER_MEMORY_SELECT_N    <= 1'b1;
                            MIDRANGE_MEMORY_SELECT_N <= 4'hf;
                            PERIPHERAL_SELECT_N      <= 7'h7f;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// *** verification/chip_select_decoder_props.sv ***
// Checker that watches the decoder's ports for window, timing and bus-hold relations.
`timescale 1ns/1ps
`include "chip_select_decoder_consts.vh"
module chip_select_decoder_props (
    input wire        CLK_SYS,
    input wire        RST,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PREADY,
    input wire        PWRITE,
    input wire [7:0]  PADDR,
    input wire [31:0] PWDATA,
    input wire        CYCLE_START,
    input wire [19:0] CYCLE_ADDR,
    input wire [2:0]  CYCLE_KIND,
    input wire        BUS_GRANT_ACKNOWLEDGE,
    input wire        CYCLE_DONE,
    input wire        UPPER_MEMORY_SELECT_N,
    input wire        LOWER_MEMORY_SELECT_N,
    input wire [3:0]  MIDRANGE_MEMORY_SELECT_N,
    input wire [6:0]  PERIPHERAL_SELECT_N
);
    reg  [19:0] addr_q;
    reg  [2:0]  kind_q;
    reg  [1:0]  mid_wait_q;
    reg  [2:0]  held_q;
    wire [12:0] sel_n = {UPPER_MEMORY_SELECT_N, LOWER_MEMORY_SELECT_N, MIDRANGE_MEMORY_SELECT_N, PERIPHERAL_SELECT_N};
    wire        mem_kind = (kind_q >= `CSD_KIND_MEM_RD) && (kind_q <= `CSD_KIND_PREFETCH);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    // The last started cycle is latched, so each select is judged against its own address and kind.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            addr_q <= 20'h00000;
            kind_q <= 3'h0;
        end else if (CYCLE_START) begin
            addr_q <= CYCLE_ADDR;
            kind_q <= CYCLE_KIND;
        end
    end
    a_grant_idle: assert property ($past(BUS_GRANT_ACKNOWLEDGE) |-> sel_n == 13'h1fff && !CYCLE_DONE)
        else $error("select or done active while the bus is granted away");
    a_done_release: assert property (CYCLE_DONE |-> sel_n == 13'h1fff)
        else $error("selects still active when the cycle finished");
    // The shared wait count is shadowed from the bus, so a mid-range cycle is held to its own floor.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mid_wait_q <= 2'h0;
            held_q     <= 3'h0;
        end else begin
            if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `CSD_OFS_SHARED_CTRL) begin
                mid_wait_q <= PWDATA[`CSD_WAIT_MSB:`CSD_WAIT_LSB];
            end
            held_q <= (sel_n == 13'h1fff) ? 3'h0 : held_q + {2'h0, held_q != 3'h7};
        end
    end
    a_wait_floor: assert property (CYCLE_DONE && $past(MIDRANGE_MEMORY_SELECT_N) != 4'hf
        |-> held_q > {1'b0, mid_wait_q})
        else $error("mid-range cycle finished before its wait states elapsed");
    a_select_hold: assert property (!CYCLE_DONE && !$past(CYCLE_START) && !$past(BUS_GRANT_ACKNOWLEDGE)
        |-> $stable(sel_n))
        else $error("selects changed in mid-cycle");
    a_upper_mem_only: assert property (!UPPER_MEMORY_SELECT_N || MIDRANGE_MEMORY_SELECT_N != 4'hf |-> mem_kind)
        else $error("upper or mid-range select on a non-memory cycle");
    a_upper_range: assert property (!UPPER_MEMORY_SELECT_N |-> addr_q[19:18] == 2'b11)
        else $error("upper select below the top 256 Kbytes");
    a_lower_range: assert property (!LOWER_MEMORY_SELECT_N |-> addr_q[19:18] == 2'b00 && mem_kind)
        else $error("lower select above the first 256 Kbytes");
    a_periph_line: assert property (PERIPHERAL_SELECT_N != 7'h7f |-> addr_q[9:7] != 3'h7
        && !PERIPHERAL_SELECT_N[addr_q[9:7]] && $onehot(~PERIPHERAL_SELECT_N))
        else $error("wrong peripheral line for the address");
    a_mid_quarter: assert property (MIDRANGE_MEMORY_SELECT_N != 4'hf |-> $onehot(~MIDRANGE_MEMORY_SELECT_N))
        else $error("more than one mid-range line active");
    a_apb_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("register access not answered after one wait");
    c_upper_mid: cover property (!UPPER_MEMORY_SELECT_N && MIDRANGE_MEMORY_SELECT_N != 4'hf);
    c_lower_periph: cover property (!LOWER_MEMORY_SELECT_N && PERIPHERAL_SELECT_N != 7'h7f);
    c_grant_start: cover property (BUS_GRANT_ACKNOWLEDGE && CYCLE_START);
endmodule

// *** verification/ext_device_model.sv ***
// Memory and peripheral devices on the system bus: ready comes a set number of cycles after selection.
`timescale 1ns/1ps
module ext_device_model (
    input wire        CLK_SYS,
    input wire        RST,
    input wire [12:0] sel_n,
    input wire [4:0]  delay,
    output reg        ready
);
    reg [4:0] count_q;
    // A released ready line reads inactive, so a cycle that hits nothing waits for ever.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            count_q <= 5'h00;
            ready <= 1'b0;
        end else if (&sel_n) begin
            count_q <= 5'h00;
            ready <= 1'b0;
        end else if (count_q >= delay) begin
            ready <= 1'b1;
        end else begin
            count_q <= count_q + 5'h01;
        end
    end
endmodule

// *** verification/chip_select_decoder_bench.sv ***
// Self-checking bench for the chip-select decoder with a bus device model.
`timescale 1ns/1ps
`include "chip_select_decoder_consts.vh"
bind chip_select_decoder chip_select_decoder_props chip_select_decoder_props_i (.CLK_SYS(CLK_SYS), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .CYCLE_START(CYCLE_START), .CYCLE_ADDR(CYCLE_ADDR),
    .CYCLE_KIND(CYCLE_KIND), .BUS_GRANT_ACKNOWLEDGE(BUS_GRANT_ACKNOWLEDGE), .CYCLE_DONE(CYCLE_DONE),
    .UPPER_MEMORY_SELECT_N(UPPER_MEMORY_SELECT_N), .LOWER_MEMORY_SELECT_N(LOWER_MEMORY_SELECT_N),
    .MIDRANGE_MEMORY_SELECT_N(MIDRANGE_MEMORY_SELECT_N), .PERIPHERAL_SELECT_N(PERIPHERAL_SELECT_N));
module chip_select_decoder_bench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0;
    reg         start = 1'b0;
    reg  [19:0] caddr = 20'h0;
    reg  [2:0]  ckind = 3'h0;
    reg         grant = 1'b0;
    reg  [4:0]  delay = 5'h00;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        ready;
    wire        done;
    wire        upper_n;
    wire        lower_n;
    wire [3:0]  mid_n;
    wire [6:0]  periph_n;
    wire [12:0] sel_n = {upper_n, lower_n, mid_n, periph_n};
    reg  [31:0] rd;
    reg         err;
    reg  [12:0] seen;
    integer     n;
    integer     i;
    integer     num_errors = 0;
    integer     comparisons = 0;
    integer     cycles = 0;
    chip_select_decoder chip_select_decoder_i (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CYCLE_START(start), .CYCLE_ADDR(caddr), .CYCLE_KIND(ckind), .BUS_GRANT_ACKNOWLEDGE(grant),
        .BUS_READY(ready), .CYCLE_DONE(done), .UPPER_MEMORY_SELECT_N(upper_n), .LOWER_MEMORY_SELECT_N(lower_n),
        .MIDRANGE_MEMORY_SELECT_N(mid_n), .PERIPHERAL_SELECT_N(periph_n));
    ext_device_model ext_device_model_i (.CLK_SYS(clk), .RST(rst), .sel_n(sel_n), .delay(delay), .ready(ready));
    always #20 clk = ~clk;
    task check(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("mismatches %0d comparisons %0d", num_errors, comparisons);
            if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // The timeout is generous against the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            complete_run;
        end
    end
    // The request stands until the edge that sees ready; data is taken and the bus released at that edge.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
            @(posedge clk) penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) begin
                @(posedge clk);
            end
            rd = prdata;
            err = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    // Starts one bus cycle, samples the selects it raises and counts cycles until it finishes.
    task run_cycle(input [19:0] a, input [2:0] k);
        begin
            @(posedge clk) {start, caddr, ckind} <= {1'b1, a, k};
            @(posedge clk) start <= 1'b0;
            #1 seen = sel_n;
            n = 0;
            while (done !== 1'b1 && n < 40) begin
                @(posedge clk) #1;
                n = n + 1;
            end
        end
    endtask
    task t_reset;
        begin
            check(sel_n, 13'h1fff);
            apb(0, `CSD_OFS_STATUS, 32'h0);
            check(rd, 32'h0);
            apb(0, 8'h18, 32'h0);
            check({err, rd}, {1'b1, 32'h0});
            $display("reset test done");
        end
    endtask
    task t_upper;
        begin
            apb(0, `CSD_OFS_UPPER_CTRL, 32'h0);
            apb(0, `CSD_OFS_STATUS, 32'h0);
            check(rd[3:0], 4'h2);
            run_cycle(20'hfffff, `CSD_KIND_MEM_RD);
            check(seen, 13'h0fff);
            check(n >= 2, 1);
            apb(1, `CSD_OFS_UPPER_CTRL, 32'h0023);
            delay = 5'd12;
            run_cycle(20'hff000, `CSD_KIND_MEM_RD);
            check(seen, 13'h0fff);
            check(n >= 13 && n < 30, 1);
            delay = 5'd0;
            run_cycle(20'hff000, `CSD_KIND_PREFETCH);
            check(n >= 5, 1);
            apb(1, `CSD_OFS_UPPER_CTRL, 32'h0025);
            delay = 5'd20;
            run_cycle(20'hff000, `CSD_KIND_MEM_WR);
            check(n, 2);
            apb(0, `CSD_OFS_STATUS, 32'h0);
            check(rd[1], 1'b1);
            $display("upper window test done");
        end
    endtask
    task t_lower_periph;
        begin
            apb(1, `CSD_OFS_LOWER_CTRL, 32'h0006);
            apb(1, `CSD_OFS_SHARED_CTRL, 32'h0087);
            apb(1, `CSD_OFS_PERIPH_CTRL, 32'h0045);
            run_cycle(20'h003ff, `CSD_KIND_MEM_RD);
            check(seen, 13'h17ff);
            check(n, 3);
            for (i = 0; i < 14; i = i + 1) begin
                run_cycle({10'h001, i[3:1], 7'h00} | {13'h0, {7{i[0]}}}, `CSD_KIND_MEM_RD);
                check(seen, 13'h1fff ^ (13'h1 << i[3:1]));
                check(n, (i[3:1] < 3'h4) ? 2 : 4);
            end
            $display("lower and peripheral test done");
        end
    endtask
    task t_overlap;
        begin
            apb(1, `CSD_OFS_PERIPH_CTRL, 32'h0005);
            run_cycle(20'h00000, `CSD_KIND_MEM_RD);
            check(seen, 13'h17fe);
            check(n, 3);
            run_cycle(20'h00200, `CSD_KIND_MEM_WR);
            check({seen, n[3:0]}, {13'h17ef, 4'h3});
            $display("overlap test done");
        end
    endtask
    task t_mid;
        begin
            apb(1, `CSD_OFS_SHARED_CTRL, 32'h00e7);
            apb(1, `CSD_OFS_MID_CTRL, 32'h8000);
            for (i = 0; i < 4; i = i + 1) begin
                run_cycle({1'b1, i[1:0], 17'h0}, `CSD_KIND_MEM_RD);
                check({seen, n[3:0]}, {13'h1fff ^ (13'h80 << i[1:0]), 4'h4});
            end
            run_cycle(20'hfffff, `CSD_KIND_MEM_RD);
            check({seen, n[3:0]}, {13'h0bff, 4'h4});
            $display("mid-range test done");
        end
    endtask
    task t_space;
        begin
            apb(1, `CSD_OFS_SHARED_CTRL, 32'h0067);
            apb(1, `CSD_OFS_PERIPH_CTRL, 32'hff05);
            for (i = 1; i < 6; i = i + 1) begin
                run_cycle(20'hff000, i[2:0]);
                check(seen, (i < 4) ? 13'h0bff : 13'h1ffe);
                check(n, (i < 4) ? 4 : 2);
            end
            $display("space select test done");
        end
    endtask
    task t_grant;
        begin
            @(posedge clk) grant <= 1'b1;
            run_cycle(20'h00000, `CSD_KIND_MEM_RD);
            check({seen, n[5:0]}, {13'h1fff, 6'd40});
            @(posedge clk) grant <= 1'b0;
            run_cycle(20'h00000, `CSD_KIND_MEM_RD);
            check({seen, n[3:0]}, {13'h17ff, 4'h3});
            $display("bus hold test done");
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_upper;
        t_lower_periph;
        t_overlap;
        t_mid;
        t_space;
        t_grant;
        complete_run;
    end
endmodule
